/* sliced_datapath.sv */
// Top of the eight-slice 32-bit datapath with working register addressing.
`timescale 1ns/100ps
`include "datapath_params.svh"

// What this block does
// - Each 4-bit slice flags zero only when all its result bits are zero.
// - Sign output equals the most significant ALU result bit.
// - RAM read in the first phase, written in the closing phase.
// - Q register loads at the clock edge ending the microcycle.
// - 32 bits from eight 4-bit slices, 32-bit Q, sixteen-word RAM.
// - Only eight working registers can be written or read on port B, and four read on port A; the other eight stay unaddressed.
// - Three arithmetic and five logic operations chosen by function code.
// - Either operand can be zero, paired with input, Q, A or B.
// - RAM write data optionally shifted one bit left or right.
// - Q register shifts one bit left or right under destination control.
// - Shift routing lets data rotate within or pass between Q and RAM.
// - Output bus carries ALU result or RAM port A per destination.
// - RAM reads A and B together; equal addresses give same word.
// - When enabled, the microcycle ends by writing the B address.
// - Only low three write and low two read address bits driven.
// - Decode microword writes register 4 if bit 9 set, else 0.
// - Memory request microword writes register 5.
// - Move uses bits 8:7 on both ports; modifier 2 sets bit 2.
// - Basic uses bits 8:7 on both ports, write bit 2 zero.
// - Extended reads from bits 10:9 and writes to bits 8:7.
// - Misc writes to bit 7 alone with bit 8 kept zero; reads use bits 8:7.

module sliced_datapath (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Datapath results
	output logic [31:0] y_bus,
	output datapath_pkg::flags_type flags
);
	import datapath_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ctrl_type ctrl_q;
	uword_type uword_q;
	logic [31:0] din_q;
	logic [31:0] q_q;
	logic [31:0] y_q;
	flags_type flags_q;
	state_type state_q;
	logic [31:0] hrdata_q;
	logic wr_pend_q;
	logic [31:0] wr_addr_q;
	logic [2:0] b_low;
	logic [1:0] a_low;
	ports_type ports;
	logic [31:0] a_data;
	logic [31:0] b_data;
	logic [31:0] r_op;
	logic [31:0] s_op;
	logic [32:0] sum;
	logic [31:0] f;
	logic [7:0] slice_zero;
	logic zero_all;
	logic ovf;
	logic ram_right_in;
	logic ram_left_in;
	logic q_right_in;
	logic q_left_in;
	logic [31:0] ram_wdata;
	logic ram_we;
	logic [31:0] q_d;
	logic [31:0] y_d;
	logic addr_phase;
	logic [31:0] read_mux;
	logic go;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// The slave never stalls, so every transfer finishes with zero wait.
	assign hreadyout = 1'b1;
	assign hresp = `HRESP_OKAY;
	assign hrdata = hrdata_q;
	assign addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ);

	always_ff @(posedge clock) begin
		if (reset) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= `ZERO_WORD;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			wr_addr_q <= haddr;
		end
	end

	always_comb begin
		read_mux = `ZERO_WORD;
		if (haddr == `ADDR_CTRL) begin
			read_mux = ctrl_q;
		end else if (haddr == `ADDR_UWORD) begin
			read_mux = uword_q;
		end else if (haddr == `ADDR_DIN) begin
			read_mux = din_q;
		end else if (haddr == `ADDR_STATUS) begin
			read_mux = flags_q;
		end else if (haddr == `ADDR_YOUT) begin
			read_mux = y_q;
		end else if (haddr == `ADDR_QOUT) begin
			read_mux = q_q;
		end else if (haddr == `ADDR_PORTS) begin
			read_mux = {24'h00_0000, ports};
		end
	end

	// Read data is captured at the address phase so it comes from a flip-flop.
	always_ff @(posedge clock) begin
		if (reset) begin
			hrdata_q <= `ZERO_WORD;
		end else if (addr_phase && !hwrite) begin
			hrdata_q <= read_mux;
		end
	end

	// Control words are frozen during a microcycle so addresses stay stable.
	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_q <= `CTRL_RESET;
			uword_q <= `ZERO_WORD;
			din_q <= `ZERO_WORD;
		end else if (wr_pend_q && state_q == idle) begin
			if (wr_addr_q == `ADDR_CTRL) begin
				ctrl_q <= hwdata;
			end else if (wr_addr_q == `ADDR_UWORD) begin
				uword_q <= hwdata;
			end else if (wr_addr_q == `ADDR_DIN) begin
				din_q <= hwdata;
			end
		end
	end

	assign go = wr_pend_q && (wr_addr_q == `ADDR_GO) && (state_q == idle);

	// ----------------------------------------
	// Microcycle sequencer
	// ----------------------------------------
	// Fetch is the read phase, execute the closing write phase.
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= idle;
		end else begin
			case (state_q)
				idle: begin
					if (go) begin
						state_q <= fetch;
					end
				end
				fetch: begin
					state_q <= execute;
				end
				default: begin
					state_q <= idle;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Working register address generation
	// ----------------------------------------
	always_comb begin
		b_low = 3'h0;
		a_low = 2'h0;
		case (ctrl_q.format)
			`FMT_DECODE: begin
				b_low = {uword_q.microword_bits[9], 2'h0};
			end
			`FMT_MEMREQ: begin
				b_low = `WR_MEMADDR;
			end
			`FMT_MOVE: begin
				b_low[2] = (uword_q.datapath_modifier_field == `MOD_HIGH_BANK);
				b_low[1:0] = uword_q.microword_bits[8:7];
				a_low = uword_q.microword_bits[8:7];
			end
			`FMT_BASIC: begin
				b_low = {1'b0, uword_q.microword_bits[8:7]};
				a_low = uword_q.microword_bits[8:7];
			end
			`FMT_EXTENDED: begin
				b_low = {1'b0, uword_q.microword_bits[8:7]};
				a_low = uword_q.microword_bits[10:9];
			end
			`FMT_MISC: begin
				b_low = {2'h0, uword_q.microword_bits[7]};
				a_low = uword_q.microword_bits[8:7];
			end
			default: begin
				b_low = 3'h0;
				a_low = 2'h0;
			end
		endcase
	end

	// Upper address lines are tied low, limiting writes and port B reads to eight words and port A reads to four.
	assign ports.write_port_addr = {1'b0, b_low};
	assign ports.read_port_addr = {2'h0, a_low};

	reg_ram ram (
		.clock(clock),
		.a_addr(ports.read_port_addr),
		.b_addr(ports.write_port_addr),
		.a_data(a_data),
		.b_data(b_data),
		.write_en(ram_we),
		.write_data(ram_wdata)
	);

	// ----------------------------------------
	// Operand selection
	// ----------------------------------------
	// A zero operand is a disabled input, paired with D, Q, A or B.
	always_comb begin
		r_op = `ZERO_WORD;
		s_op = `ZERO_WORD;
		case (ctrl_q.src)
			`SRC_AQ: begin
				r_op = a_data;
				s_op = q_q;
			end
			`SRC_AB: begin
				r_op = a_data;
				s_op = b_data;
			end
			`SRC_ZQ: begin
				s_op = q_q;
			end
			`SRC_ZB: begin
				s_op = b_data;
			end
			`SRC_ZA: begin
				s_op = a_data;
			end
			`SRC_DA: begin
				r_op = din_q;
				s_op = a_data;
			end
			`SRC_DQ: begin
				r_op = din_q;
				s_op = q_q;
			end
			default: begin
				r_op = din_q;
			end
		endcase
	end

	// ----------------------------------------
	// ALU
	// ----------------------------------------
	// Subtraction is done as addition of the complement, as in the slices.
	always_comb begin
		sum = {1'b0, r_op} + {1'b0, s_op} + {32'h0000_0000, ctrl_q.carry_in};
		f = sum[31:0];
		case (ctrl_q.func)
			`FN_ADD: begin
				sum = {1'b0, r_op} + {1'b0, s_op} + {32'h0000_0000, ctrl_q.carry_in};
				f = sum[31:0];
			end
			`FN_SUBR: begin
				sum = {1'b0, ~r_op} + {1'b0, s_op} + {32'h0000_0000, ctrl_q.carry_in};
				f = sum[31:0];
			end
			`FN_SUBS: begin
				sum = {1'b0, r_op} + {1'b0, ~s_op} + {32'h0000_0000, ctrl_q.carry_in};
				f = sum[31:0];
			end
			`FN_OR: begin
				f = r_op | s_op;
			end
			`FN_AND: begin
				f = r_op & s_op;
			end
			`FN_MASK: begin
				f = ~r_op & s_op;
			end
			`FN_XOR: begin
				f = r_op ^ s_op;
			end
			default: begin
				f = ~(r_op ^ s_op);
			end
		endcase
	end

	// Overflow must use the operand as it enters the adder, complemented when subtracting.
	assign ovf = (ctrl_q.func <= `FN_SUBS) && (sum[31] ^ sum[32]
		^ (r_op[31] ^ (ctrl_q.func == `FN_SUBR)) ^ (s_op[31] ^ (ctrl_q.func == `FN_SUBS)));

	// One zero detector per slice, wired together as the open-collector bus would be.
	for (genvar i = 0; i < `SLICES; i++) begin : slice
		assign slice_zero[i] = (f[4*i+:4] == 4'h0);
	end

	assign zero_all = &slice_zero;

	// ----------------------------------------
	// Shift routing
	// ----------------------------------------
	// Cross routing forms a 64-bit shift with RAM as the upper half.
	always_comb begin
		ram_right_in = 1'b0;
		ram_left_in = 1'b0;
		q_right_in = 1'b0;
		q_left_in = 1'b0;
		case (ctrl_q.shift_route)
			`ROUTE_ROTATE: begin
				ram_right_in = f[0];
				ram_left_in = f[31];
				q_right_in = q_q[0];
				q_left_in = q_q[31];
			end
			`ROUTE_CROSS: begin
				ram_right_in = q_q[0];
				ram_left_in = q_q[31];
				q_right_in = f[0];
				q_left_in = f[31];
			end
			`ROUTE_ONES: begin
				ram_right_in = 1'b1;
				ram_left_in = 1'b1;
				q_right_in = 1'b1;
				q_left_in = 1'b1;
			end
			default: begin
				ram_right_in = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Destination control
	// ----------------------------------------
	always_comb begin
		ram_wdata = f;
		q_d = q_q;
		y_d = f;
		ram_we = 1'b0;
		case (ctrl_q.dest)
			`DEST_LOADQ: begin
				q_d = f;
			end
			`DEST_WRBA: begin
				ram_we = 1'b1;
				y_d = a_data;
			end
			`DEST_WRBF: begin
				ram_we = 1'b1;
			end
			`DEST_RSHRQ: begin
				ram_we = 1'b1;
				ram_wdata = {ram_right_in, f[31:1]};
				q_d = {q_right_in, q_q[31:1]};
			end
			`DEST_RSHR: begin
				ram_we = 1'b1;
				ram_wdata = {ram_right_in, f[31:1]};
			end
			`DEST_LSHRQ: begin
				ram_we = 1'b1;
				ram_wdata = {f[30:0], ram_left_in};
				q_d = {q_q[30:0], q_left_in};
			end
			`DEST_LSHR: begin
				ram_we = 1'b1;
				ram_wdata = {f[30:0], ram_left_in};
			end
			default: begin
				ram_we = 1'b0;
			end
		endcase
		// RAM is only written in the closing phase of a microcycle.
		ram_we = ram_we && (state_q == execute);
	end

	// ----------------------------------------
	// Result registers
	// ----------------------------------------
	// Q takes its new value at the edge that ends the microcycle.
	always_ff @(posedge clock) begin
		if (reset) begin
			q_q <= `ZERO_WORD;
		end else if (state_q == execute) begin
			q_q <= q_d;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			y_q <= `ZERO_WORD;
		end else if (state_q == execute) begin
			y_q <= y_d;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			flags_q <= `ZERO_WORD;
		end else begin
			flags_q.busy <= go || (state_q == fetch);
			if (state_q == execute) begin
				flags_q.zero <= zero_all;
				flags_q.sign <= f[31];
				flags_q.carry <= (ctrl_q.func <= `FN_SUBS) && sum[32];
				flags_q.overflow <= ovf;
			end
		end
	end

	assign y_bus = y_q;
	assign flags = flags_q;

endmodule : sliced_datapath

/* datapath_params.svh */
// Constants for the sliced datapath: bus offsets, reset values and control codes.
`ifndef DATAPATH_PARAMS_SVH
`define DATAPATH_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CTRL 32'h0000_0000
`define ADDR_UWORD 32'h0000_0004
`define ADDR_DIN 32'h0000_0008
`define ADDR_GO 32'h0000_000C
`define ADDR_STATUS 32'h0000_0010
`define ADDR_YOUT 32'h0000_0014
`define ADDR_QOUT 32'h0000_0018
`define ADDR_PORTS 32'h0000_001C

// ----------------------------------------
// Reset values and bus constants
// ----------------------------------------
`define ZERO_WORD 32'h0000_0000
`define CTRL_RESET 32'h0000_0040
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'h0

// ----------------------------------------
// Source operand codes
// ----------------------------------------
`define SRC_AQ 3'h0
`define SRC_AB 3'h1
`define SRC_ZQ 3'h2
`define SRC_ZB 3'h3
`define SRC_ZA 3'h4
`define SRC_DA 3'h5
`define SRC_DQ 3'h6
`define SRC_DZ 3'h7

// ----------------------------------------
// Function codes
// ----------------------------------------
`define FN_ADD 3'h0
`define FN_SUBR 3'h1
`define FN_SUBS 3'h2
`define FN_OR 3'h3
`define FN_AND 3'h4
`define FN_MASK 3'h5
`define FN_XOR 3'h6
`define FN_XNOR 3'h7

// ----------------------------------------
// Destination codes
// ----------------------------------------
`define DEST_LOADQ 3'h0
`define DEST_NOP 3'h1
`define DEST_WRBA 3'h2
`define DEST_WRBF 3'h3
`define DEST_RSHRQ 3'h4
`define DEST_RSHR 3'h5
`define DEST_LSHRQ 3'h6
`define DEST_LSHR 3'h7

// ----------------------------------------
// Microword formats and address constants
// ----------------------------------------
`define FMT_DECODE 3'h0
`define FMT_MEMREQ 3'h1
`define FMT_MOVE 3'h2
`define FMT_BASIC 3'h3
`define FMT_EXTENDED 3'h4
`define FMT_MISC 3'h5
`define MOD_HIGH_BANK 2'h2
`define WR_MEMADDR 3'h5
`define ROUTE_ZERO 2'h0
`define ROUTE_ROTATE 2'h1
`define ROUTE_CROSS 2'h2
`define ROUTE_ONES 2'h3
`define SLICES 8

`endif

/* datapath_pkg.sv */
// Types shared by the sliced datapath files.
package datapath_pkg;

	// ----------------------------------------
	// Register layouts
	// ----------------------------------------
	typedef struct packed {
		logic [16:0] reserved;
		logic [1:0] shift_route;
		logic [2:0] format;
		logic carry_in;
		logic [2:0] dest;
		logic [2:0] func;
		logic [2:0] src;
	} ctrl_type;

	typedef struct packed {
		logic [18:0] reserved;
		logic [1:0] datapath_modifier_field;
		logic [10:0] microword_bits;
	} uword_type;

	typedef struct packed {
		logic [26:0] reserved;
		logic busy;
		logic overflow;
		logic carry;
		logic sign;
		logic zero;
	} flags_type;

	typedef struct packed {
		logic [3:0] read_port_addr;
		logic [3:0] write_port_addr;
	} ports_type;

	// ----------------------------------------
	// Microcycle sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {
		idle,
		fetch,
		execute
	} state_type;

endpackage : datapath_pkg

/* reg_ram.sv */
// Sixteen-word two-read one-write working register memory.
`timescale 1ns/100ps

module reg_ram (
	// Clock
	input wire logic clock,
	// Read ports
	input wire logic [3:0] a_addr,
	input wire logic [3:0] b_addr,
	output logic [31:0] a_data,
	output logic [31:0] b_data,
	// Write port
	input wire logic write_en,
	input wire logic [31:0] write_data
);

	logic [31:0] mem [0:15];

	// Both ports read at once; equal addresses give the same word.
	always_ff @(posedge clock) begin
		a_data <= mem[a_addr];
		b_data <= mem[b_addr];
	end

	// Writes always go to the B address.
	always_ff @(posedge clock) begin
		if (write_en) begin
			mem[b_addr] <= write_data;
		end
	end

endmodule : reg_ram

/* sliced_datapath_assertions.sv */
// Concurrent checks on the ports of the sliced datapath.
`timescale 1ns/100ps
`include "datapath_params.svh"

module sliced_datapath_assertions (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	// Results
	input wire logic [31:0] y_bus,
	input wire datapath_pkg::flags_type flags
);
	import datapath_pkg::*;

	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// The control word is shadowed because with a port A output the flags no longer match y_bus.
	logic take;
	logic wr_q;
	logic ports_q;
	logic [31:0] addr_q;
	ctrl_type ctrl_q;
	assign take = hsel && hready && htrans == `HTRANS_NONSEQ;

	always_ff @(posedge clock) begin
		if (reset) begin
			wr_q <= 1'b0;
			ports_q <= 1'b0;
			addr_q <= 32'h0;
		end else begin
			wr_q <= take && hwrite;
			ports_q <= take && !hwrite && haddr == `ADDR_PORTS;
			addr_q <= haddr;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_q <= `CTRL_RESET;
		end else if (wr_q && addr_q == `ADDR_CTRL && !flags.busy) begin
			ctrl_q <= hwdata;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	sequence go_take;
		take && hwrite && haddr == `ADDR_GO && !flags.busy;
	endsequence
	sequence cycle_run;
		flags.busy ##1 flags.busy ##1 !flags.busy;
	endsequence
	sequence cycle_end;
		$fell(flags.busy);
	endsequence

	chk_go_starts: assert property (go_take |-> ##2 cycle_run)
		else $error("microcycle did not run two cycles after go");
	chk_zero_flag: assert property (cycle_end ##0 ctrl_q.dest != `DEST_WRBA
		|-> flags.zero == (y_bus == 32'h0))
		else $error("zero flag disagrees with result");
	chk_sign_bit: assert property (cycle_end ##0 ctrl_q.dest != `DEST_WRBA
		|-> flags.sign == y_bus[31])
		else $error("sign flag disagrees with result msb");
	chk_logic_flags: assert property (cycle_end ##0 ctrl_q.func >= `FN_OR
		|-> !flags.carry && !flags.overflow)
		else $error("carry or overflow set by a logic operation");
	chk_y_holds: assert property (!$fell(flags.busy) |-> $stable(y_bus) && $stable(flags.zero))
		else $error("output bus changed outside a microcycle end");
	chk_ports_tied: assert property (ports_q |-> hrdata[31:6] == 26'h0 && !hrdata[3])
		else $error("undriven address bit is not zero");
	chk_ports_six: assert property (ports_q |-> hrdata[2:0] <= 3'h5)
		else $error("write port address beyond the six used registers");
	chk_ready_okay: assert property (hreadyout && flags.reserved == 27'h0)
		else $error("wait state or stray flag bit");
endmodule : sliced_datapath_assertions

/* microword_source.sv */
// Microword source standing in for the microsequencer.
`timescale 1ns/100ps

module microword_source (
	// Step select
	input wire logic [2:0] step,
	// Microword
	output datapath_pkg::uword_type uword
);
	import datapath_pkg::*;

	// ----------------------------------------
	// Microword table
	// ----------------------------------------
	// Fields only ever name registers 0 to 5, so the unused locations stay untouched.
	always_comb begin
		uword = '0;
		case (step)
			3'h0: uword.microword_bits = 11'h200;
			3'h1: uword.microword_bits = 11'h0;
			3'h2: uword.microword_bits = 11'h180;
			3'h3: begin
				uword.datapath_modifier_field = `MOD_HIGH_BANK;
				uword.microword_bits = 11'h80;
			end
			3'h5: uword.microword_bits = 11'h680;
			3'h6: uword.microword_bits = 11'h80;
			default: uword.microword_bits = 11'h100;
		endcase
	end
endmodule : microword_source

/* testbench.sv */
// Self-checking bench for the sliced datapath.
`timescale 1ns/100ps
`include "datapath_params.svh"

module testbench;
	import datapath_pkg::*;

	// ----------------------------------------
	// Signals, instances and tasks
	// ----------------------------------------
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] y_bus;
	flags_type flags;
	logic [2:0] step = 3'h0;
	uword_type uword;
	logic [31:0] rd;
	logic [15:0] rows [0:8];
	logic [31:0] dp [0:19][0:4];
	int n_errors = 0;
	int comparisons = 0;

	initial begin
		forever #10 clock = ~clock;
	end

	sliced_datapath DUT (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .y_bus(y_bus), .flags(flags));
	microword_source source (.step(step), .uword(uword));

	task automatic summarize();
		$display("Counts: %0d mismatches in %0d comparisons", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic edge_ready();
		int n;
		n = 0;
		@(posedge clock);
		while (hreadyout !== 1'b1 && n < 64) begin
			@(posedge clock);
			n++;
		end
		if (n == 64) begin
			n_errors++;
			summarize();
		end
	endtask : edge_ready

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= `HTRANS_NONSEQ;
		hwrite <= w;
		edge_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		edge_ready();
		rd = hrdata;
	endtask : bus

	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check($sformatf("register %h", a), exp, rd);
		check("hresp", {31'h0, `HRESP_OKAY}, {31'h0, hresp});
	endtask : rchk

	task automatic run(input logic [31:0] ctrl, input logic [31:0] din);
		int n;
		bus(1'b1, `ADDR_DIN, din);
		bus(1'b1, `ADDR_CTRL, ctrl);
		bus(1'b1, `ADDR_GO, 32'h0);
		n = 0;
		rd = 32'h10;
		while (rd[4] && n < 16) begin
			bus(1'b0, `ADDR_STATUS, 32'h0);
			n++;
		end
		if (n == 16) begin
			n_errors++;
			summarize();
		end
		bus(1'b0, `ADDR_YOUT, 32'h0);
	endtask : run

	function automatic logic [31:0] cw(input logic [2:0] s, f, d, input logic [1:0] r, input logic c);
		return {17'h0, r, `FMT_BASIC, c, d, f, s};
	endfunction : cw

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rows = '{16'h0004, 16'h0100, 16'h1005, 16'h2233, 16'h2315, 16'h3422, 16'h4531,
			16'h5611, 16'h6400};
		dp[0] = '{cw(7, 3, 3, 0, 0), 32'h8000_0001, 32'h8000_0001, 32'h0, 32'h2};
		dp[1] = '{cw(4, 0, 0, 0, 0), 32'h0, 32'h8000_0001, 32'h8000_0001, 32'h2};
		dp[2] = '{cw(3, 3, 5, 1, 0), 32'h0, 32'h8000_0001, 32'h8000_0001, 32'h2};
		dp[3] = '{cw(7, 3, 2, 0, 0), 32'h5, 32'hC000_0000, 32'h8000_0001, 32'h0};
		dp[4] = '{cw(2, 3, 6, 0, 0), 32'h0, 32'h8000_0001, 32'h2, 32'h2};
		dp[5] = '{cw(1, 6, 1, 0, 0), 32'h0, 32'h0, 32'h2, 32'h1};
		dp[6] = '{cw(3, 3, 4, 3, 0), 32'h0, 32'h2, 32'h8000_0001, 32'h0};
		dp[7] = '{cw(3, 3, 6, 2, 0), 32'h0, 32'h8000_0001, 32'h3, 32'h2};
		dp[8] = '{cw(4, 3, 7, 0, 0), 32'h0, 32'h3, 32'h3, 32'h0};
		dp[9] = '{cw(5, 0, 1, 0, 1), 32'h1, 32'h8, 32'h3, 32'h0};
		dp[10] = '{cw(0, 2, 1, 0, 1), 32'h0, 32'h3, 32'h3, 32'h0};
		dp[11] = '{cw(6, 1, 1, 0, 1), 32'h1, 32'h2, 32'h3, 32'h0};
		dp[12] = '{cw(7, 0, 1, 0, 0), 32'h1234, 32'h1234, 32'h3, 32'h0};
		dp[13] = '{cw(7, 1, 1, 0, 0), 32'h1234, 32'hFFFF_EDCB, 32'h3, 32'h2};
		dp[14] = '{cw(7, 2, 1, 0, 0), 32'h1234, 32'h1233, 32'h3, 32'h0};
		dp[15] = '{cw(7, 3, 1, 0, 0), 32'h1234, 32'h1234, 32'h3, 32'h0};
		dp[16] = '{cw(7, 4, 1, 0, 0), 32'h1234, 32'h0, 32'h3, 32'h1};
		dp[17] = '{cw(7, 5, 1, 0, 0), 32'h1234, 32'h0, 32'h3, 32'h1};
		dp[18] = '{cw(7, 6, 1, 0, 0), 32'h1234, 32'h1234, 32'h3, 32'h0};
		dp[19] = '{cw(7, 7, 1, 0, 0), 32'h1234, 32'hFFFF_EDCB, 32'h3, 32'h2};
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			rchk(i == 8 ? 32'h40 : 32'(i * 4), i == 0 ? `CTRL_RESET : 32'h0);
		end
		bus(1'b1, 32'h40, 32'hFFFF_FFFF);
		rchk(32'h40, 32'h0);
		for (int i = 0; i < 9; i++) begin
			step <= rows[i][10:8];
			bus(1'b1, `ADDR_CTRL, {19'h0, rows[i][14:12], 10'h40});
			bus(1'b1, `ADDR_UWORD, uword);
			rchk(`ADDR_PORTS, {24'h0, rows[i][7:0]});
		end
		step <= 3'h7;
		@(posedge clock);
		bus(1'b1, `ADDR_UWORD, uword);
		for (int i = 0; i < 20; i++) begin
			run(dp[i][0], dp[i][1]);
			check("y_bus", dp[i][2], rd);
			rchk(`ADDR_QOUT, dp[i][3]);
			bus(1'b0, `ADDR_STATUS, 32'h0);
			check("zero_sign", dp[i][4], {30'h0, rd[1:0]});
		end
		bus(1'b1, `ADDR_GO, 32'h0);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		rchk(`ADDR_QOUT, 32'h0);
		rchk(`ADDR_STATUS, 32'h0);
		summarize();
	end
endmodule : testbench

bind sliced_datapath sliced_datapath_assertions checks (.clock(clock), .reset(reset),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .y_bus(y_bus), .flags(flags));
